// file: logic/aio_pkg.sv
// Shared constants and types for the analog I/O timestamp exchange link.
// Assumes both ends run on one 250 MHz clock.
package aio_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int RTS_W = 15;
  localparam int SYS_TIME_W = 64;
  localparam int CHAN_W = 32;
  localparam int NCHAN = 4;
  localparam int CHAN_IDX_W = 2;
  localparam logic FMT_FLOAT = 1'b0;
  localparam logic FMT_INT = 1'b1;
  localparam logic FMT_RESET = FMT_FLOAT;
  localparam logic [RTS_W-1:0] RTS_RESET = 15'h0000;
  localparam int FIFO_DEPTH = 4;
  // Produced word: value, rolling stamp, system time, channel index
  localparam int WORD_W = CHAN_W + RTS_W + SYS_TIME_W + CHAN_IDX_W;
  typedef enum logic {dir_input_type_in, dir_input_type_out} dir_type;
endpackage : aio_pkg

// file: logic/aio_if.sv
// Link between the module end and the controller end.
// Assumes a shared clock and reset supplied by the surroundings.
`timescale 1ns/1ps
`default_nettype none
interface aio_if;
  // Produced data stream, module to controllers
  logic prod_valid;
  logic prod_ready;
  logic [aio_pkg::WORD_W-1:0] prod_data;
  // Configuration and commands, controller to module
  logic cfg_int_fmt;
  logic cfg_time_stamp;
  logic cfg_latch_en;
  logic cfg_clamp_en;
  logic inhibit;
  logic unlatch_req;
  logic cal_req;
  logic cal_all;
  logic [aio_pkg::CHAN_IDX_W-1:0] cal_chan;
  logic [15:0] cal_offset;
  // System time broadcast
  logic [aio_pkg::SYS_TIME_W-1:0] chassis_system_time;
  modport module_end(output prod_valid, prod_data, input prod_ready,
    input cfg_int_fmt, cfg_time_stamp, cfg_latch_en, cfg_clamp_en,
    input inhibit, unlatch_req, cal_req, cal_all, cal_chan, cal_offset,
    input chassis_system_time);
  modport ctrl_end(input prod_valid, prod_data, output prod_ready,
    output cfg_int_fmt, cfg_time_stamp, cfg_latch_en, cfg_clamp_en,
    output inhibit, unlatch_req, cal_req, cal_all, cal_chan, cal_offset,
    output chassis_system_time);
endinterface : aio_if
`default_nettype wire

// file: logic/aio_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; nrst asynchronous active low.
`timescale 1ns/1ps
`default_nettype none
module aio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, rd_ff;
  logic [AW:0] cnt_ff;
  logic push, pop;
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ff];
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : AW'(wr_ff + 1'b1);
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : AW'(rd_ff + 1'b1);
      end
      cnt_ff <= (AW+1)'(cnt_ff + push - pop);
    end
  end
endmodule : aio_fifo
`default_nettype wire

// file: logic/aio_module_end.sv
// Module end: rolling timestamp, capture, stamping, format, alarms,
// calibration offset, indicators and inhibit. Produces onto the link.
// Assumes channel samples arrive as 32-bit floats or 16-bit ints.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Free-running 15-bit millisecond rolling timestamp
// - Input scan captures current rolling timestamp
// - Output stamp updates only on converter load
// - Optionally attach chassis system time when producing
// - Stamp stays chassis time under grandmaster
// - Produce unprompted; many consumers share data
// - Calibration indicator and communication status indicator
// - Calibrate one channel or all channels
// - Add per-channel sensor offset in calibration; added here in integer format only
// - Latched alarm stays set after condition clears
// - Integer format uses 16-bit signed words
// - Integer range maps low/high to min/max counts
// - Float format uses 32-bit IEEE words
// - Default format is floating point
// - Integer format on output disables clamping
// - Controller stays off while inhibited pre-connection
// - Inhibited connection treated as nonexistent
// - Inhibited output enters program mode outputs
// - Inhibit around firmware upgrade recommended
module aio_module_end #(
  parameter aio_pkg::dir_type DIR = aio_pkg::dir_input_type_in,
  parameter int TICK_CYCLES = aio_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link
  aio_if.module_end link,
  // Front end samples or converter values
  input wire logic sample_valid,
  input wire logic [aio_pkg::CHAN_IDX_W-1:0] sample_chan,
  input wire logic [aio_pkg::CHAN_W-1:0] sample_value,
  // Alarm condition from the channel compare logic
  input wire logic alarm_cond,
  // Clamp limit and program mode value for outputs
  input wire logic [aio_pkg::CHAN_W-1:0] clamp_hi,
  input wire logic [aio_pkg::CHAN_W-1:0] program_value,
  // Converter drive
  output logic dac_load,
  output logic [aio_pkg::CHAN_W-1:0] dac_value,
  // Status
  output logic alarm_flag,
  output logic cal_led,
  output logic module_led,
  output logic sample_stall
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  // ------------------------------------------------------------
  // Millisecond tick and rolling timestamp
  // ------------------------------------------------------------
  logic [TW-1:0] tick_cnt_ff;
  logic ms_tick;
  logic [aio_pkg::RTS_W-1:0] rts_ff;
  // One-cycle enable, so the block keeps a single clock
  assign ms_tick = (tick_cnt_ff == TW'(TICK_CYCLES - 1));
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= ms_tick ? '0 : TW'(tick_cnt_ff + 1'b1);
    end
  end
  // Never reset by link events: independent of system time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rts_ff <= aio_pkg::RTS_RESET;
    end else if (ms_tick) begin
      rts_ff <= rts_ff + 1'b1;
    end
  end
  // ------------------------------------------------------------
  // Calibration offsets
  // ------------------------------------------------------------
  // Offsets persist after calibration mode ends
  logic [15:0] offs_ff [aio_pkg::NCHAN];
  logic cal_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cal_ff <= 1'b0;
      for (int i = 0; i < aio_pkg::NCHAN; i++) begin
        offs_ff[i] <= 16'h0000;
      end
    end else begin
      cal_ff <= link.cal_req;
      if (link.cal_req) begin
        for (int i = 0; i < aio_pkg::NCHAN; i++) begin
          if (link.cal_all || link.cal_chan == i[1:0]) begin
            offs_ff[i] <= link.cal_offset;
          end
        end
      end
    end
  end
  // ------------------------------------------------------------
  // Integer offset, saturated at the range ends
  // ------------------------------------------------------------
  localparam logic [15:0] INT_LO = 16'h8000;
  localparam logic [15:0] INT_HI = 16'h7fff;
  logic [15:0] int_in, int_corr;
  logic [16:0] int_sum;
  // Wrapping would fold the low end onto the high end
  always_comb begin
    int_in = sample_value[15:0];
    int_sum = {int_in[15], int_in} +
      {offs_ff[sample_chan][15], offs_ff[sample_chan]};
    if (int_sum[16] != int_sum[15]) begin
      int_corr = int_sum[16] ? INT_LO : INT_HI;
    end else begin
      int_corr = int_sum[15:0];
    end
  end
  // ------------------------------------------------------------
  // Value path: offset, format, clamp, program mode
  // ------------------------------------------------------------
  logic [aio_pkg::CHAN_W-1:0] corr_val, fmt_val, out_val;
  always_comb begin
    if (link.cfg_int_fmt == aio_pkg::FMT_INT) begin
      // Full range already spans 8000..7fff counts
      corr_val = {{16{int_corr[15]}}, int_corr};
    end else begin
      // Float offset is applied by the conversion stage upstream
      corr_val = sample_value;
    end
    fmt_val = corr_val;
    if (link.cfg_int_fmt == aio_pkg::FMT_FLOAT && link.cfg_clamp_en &&
        !corr_val[31] && corr_val > clamp_hi) begin
      fmt_val = clamp_hi;
    end
    out_val = link.inhibit ? program_value : fmt_val;
  end
  // ------------------------------------------------------------
  // Converter and stamp capture
  // ------------------------------------------------------------
  logic take;
  logic fifo_ready;
  assign take = sample_valid && fifo_ready;
  assign sample_stall = !fifo_ready;
  // Inhibit reloads the program value on every cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dac_load <= 1'b0;
      dac_value <= '0;
    end else begin
      dac_load <= (DIR == aio_pkg::dir_input_type_out) &&
        (take || link.inhibit);
      if (DIR == aio_pkg::dir_input_type_out && (take || link.inhibit)) begin
        dac_value <= out_val;
      end
    end
  end
  // ------------------------------------------------------------
  // Alarm latch
  // ------------------------------------------------------------
  // Set wins over unlatch in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarm_flag <= 1'b0;
    end else if (!link.cfg_latch_en) begin
      alarm_flag <= alarm_cond;
    end else if (alarm_cond) begin
      alarm_flag <= 1'b1;
    end else if (link.unlatch_req) begin
      alarm_flag <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // Production onto the link
  // ------------------------------------------------------------
  logic [aio_pkg::WORD_W-1:0] word;
  logic [aio_pkg::SYS_TIME_W-1:0] time_val;
  // Raw chassis time; grandmaster conversion is the consumer's job
  assign time_val = link.cfg_time_stamp ? link.chassis_system_time
    : '0;
  // Stamp field is the tick count at the push edge
  assign word = {out_val, rts_ff, time_val, sample_chan};
  // Produced per sample without any poll; ready is shared by consumers
  aio_fifo #(.WIDTH(aio_pkg::WORD_W), .DEPTH(aio_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(sample_valid && !link.inhibit),
    .in_ready(fifo_ready),
    .in_data(word),
    .out_valid(link.prod_valid),
    .out_ready(link.prod_ready),
    .out_data(link.prod_data)
  );
  // ------------------------------------------------------------
  // Indicators
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cal_led <= 1'b0;
      module_led <= 1'b0;
    end else begin
      cal_led <= cal_ff;
      module_led <= !link.inhibit;
    end
  end
endmodule : aio_module_end
`default_nettype wire

// file: logic/aio_ctrl_end.sv
// Controller end: drives configuration and commands, consumes produced words.
// Assumes a user side that requests inhibit, unlatch and calibration.
`timescale 1ns/1ps
`default_nettype none
module aio_ctrl_end (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link
  aio_if.ctrl_end link,
  // User configuration
  input wire logic user_int_fmt,
  input wire logic user_time_stamp,
  input wire logic user_latch_en,
  input wire logic user_clamp_en,
  input wire logic user_inhibit,
  input wire logic user_unlatch,
  input wire logic user_cal,
  input wire logic user_cal_all,
  input wire logic [aio_pkg::CHAN_IDX_W-1:0] user_cal_chan,
  input wire logic [15:0] user_cal_offset,
  input wire logic [aio_pkg::SYS_TIME_W-1:0] system_time,
  input wire logic consume_ready,
  // Consumed data
  output logic rx_valid,
  output logic [aio_pkg::WORD_W-1:0] rx_data,
  output logic connected
);
  // ------------------------------------------------------------
  // Configuration, withheld while inhibited
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link.cfg_int_fmt <= aio_pkg::FMT_RESET;
      link.cfg_time_stamp <= 1'b0;
      link.cfg_latch_en <= 1'b0;
      link.cfg_clamp_en <= 1'b0;
      link.inhibit <= 1'b1;
      link.unlatch_req <= 1'b0;
      link.cal_req <= 1'b0;
      link.cal_all <= 1'b0;
      link.cal_chan <= '0;
      link.cal_offset <= 16'h0000;
      link.chassis_system_time <= '0;
      connected <= 1'b0;
    end else begin
      link.inhibit <= user_inhibit;
      connected <= !user_inhibit;
      link.chassis_system_time <= system_time;
      link.unlatch_req <= user_unlatch && !user_inhibit;
      link.cal_req <= user_cal && !user_inhibit;
      link.cal_all <= user_cal_all;
      link.cal_chan <= user_cal_chan;
      link.cal_offset <= user_cal_offset;
      if (!user_inhibit) begin
        link.cfg_int_fmt <= user_int_fmt;
        link.cfg_time_stamp <= user_time_stamp;
        link.cfg_latch_en <= user_latch_en;
        link.cfg_clamp_en <= user_clamp_en;
      end
    end
  end
  // ------------------------------------------------------------
  // Consumption; queued words are drained and dropped while inhibited
  // ------------------------------------------------------------
  assign link.prod_ready = consume_ready || user_inhibit;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_valid <= 1'b0;
      rx_data <= '0;
    end else begin
      rx_valid <= link.prod_valid && consume_ready && !user_inhibit;
      if (link.prod_valid && consume_ready && !user_inhibit) begin
        rx_data <= link.prod_data;
      end
    end
  end
endmodule : aio_ctrl_end
`default_nettype wire

// file: sim/aio_link_sva.sv
// Checker for the produced stream and the controller configuration.
// Assumes one clock domain; instantiated beside the link.
`timescale 1ns/1ps
`default_nettype none
module aio_link_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link signals
  input wire logic prod_valid,
  input wire logic prod_ready,
  input wire logic [aio_pkg::WORD_W-1:0] prod_data,
  input wire logic cfg_int_fmt,
  input wire logic cfg_time_stamp,
  input wire logic cfg_latch_en,
  input wire logic inhibit,
  input wire logic [aio_pkg::SYS_TIME_W-1:0] chassis_system_time
);
  logic [aio_pkg::RTS_W-1:0] last_stamp_ff;
  logic seen_ff;
  logic [aio_pkg::RTS_W-1:0] stamp_step;
  // Modular step, so a wrap of the stamp is no fault
  assign stamp_step = prod_data[80:66] - last_stamp_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_stamp_ff <= 15'h0000;
    end else if (prod_valid && prod_ready) begin
      last_stamp_ff <= prod_data[80:66];
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen_ff <= 1'b0;
    end else if (prod_valid && prod_ready) begin
      seen_ff <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // -------------------------------------------------------------
  // Stamping settled long enough that no older word is queued
  // -------------------------------------------------------------
  sequence time_off_settled;
    (!cfg_time_stamp) [*8];
  endsequence
  sequence time_on_settled;
    (cfg_time_stamp && $stable(chassis_system_time)) [*8];
  endsequence
  prod_hold_a: assert property (
    prod_valid && !prod_ready |=> prod_valid)
    else $error("produced word withdrawn before acceptance");
  data_hold_a: assert property (
    prod_valid && !prod_ready |=> $stable(prod_data))
    else $error("produced word changed before acceptance");
  inhibit_reset_a: assert property ($rose(nrst) |-> inhibit)
    else $error("link not inhibited out of reset");
  fmt_reset_a: assert property (
    $rose(nrst) |-> cfg_int_fmt == aio_pkg::FMT_FLOAT)
    else $error("format not float out of reset");
  fmt_freeze_a: assert property (
    inhibit && $past(inhibit) |-> $stable(cfg_int_fmt))
    else $error("format changed while inhibited");
  cfg_freeze_a: assert property (
    inhibit && $past(inhibit)
    |-> $stable(cfg_latch_en) && $stable(cfg_time_stamp))
    else $error("configuration changed while inhibited");
  stamp_order_a: assert property (
    prod_valid && prod_ready && seen_ff |-> stamp_step < 15'h4000)
    else $error("rolling stamp went backwards");
  time_off_a: assert property (
    time_off_settled ##0 prod_valid |-> prod_data[65:2] == 64'h0)
    else $error("system time attached while disabled");
  time_echo_a: assert property (
    time_on_settled ##0 prod_valid
    |-> prod_data[65:2] == chassis_system_time)
    else $error("attached system time differs");
endmodule : aio_link_checker
`default_nettype wire

// file: sim/test_analog_io_timestamp_exchange.sv
// Self-checking bench: controller end and input module end on one link.
// Assumes package, link, FIFO and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_analog_io_timestamp_exchange;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic s_valid, acond, u_int, u_tst, u_latch, u_clamp, u_inh;
  logic u_unl, u_cal, u_all, cready;
  logic [1:0] s_chan, u_chan;
  logic [31:0] s_val, dac_val;
  logic [15:0] u_off;
  logic [63:0] stime;
  logic alarm_flag, cal_led, module_led, sample_stall, rx_valid, connected;
  logic dac_ld;
  logic [aio_pkg::WORD_W-1:0] rx_data, w;
  logic [14:0] prev;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  always #2 clk = ~clk;
  aio_if link();
  aio_module_end #(.DIR(aio_pkg::dir_input_type_in), .TICK_CYCLES(8))
    i_aio_module_end (.clk(clk), .nrst(nrst), .link(link),
    .sample_valid(s_valid), .sample_chan(s_chan), .sample_value(s_val),
    .alarm_cond(acond), .clamp_hi(32'h00001000),
    .program_value(32'h00000000), .dac_load(), .dac_value(),
    .alarm_flag(alarm_flag), .cal_led(cal_led), .module_led(module_led),
    .sample_stall(sample_stall));
  aio_ctrl_end i_aio_ctrl_end (.clk(clk), .nrst(nrst), .link(link),
    .user_int_fmt(u_int), .user_time_stamp(u_tst), .user_latch_en(u_latch),
    .user_clamp_en(u_clamp), .user_inhibit(u_inh), .user_unlatch(u_unl),
    .user_cal(u_cal), .user_cal_all(u_all), .user_cal_chan(u_chan),
    .user_cal_offset(u_off), .system_time(stime), .consume_ready(cready),
    .rx_valid(rx_valid), .rx_data(rx_data), .connected(connected));
  // Output end on a second link, sharing all stimulus except program_value
  aio_if link2();
  aio_module_end #(.DIR(aio_pkg::dir_input_type_out), .TICK_CYCLES(8))
    i_aio_module_end_out (.clk(clk), .nrst(nrst), .link(link2),
    .sample_valid(s_valid), .sample_chan(s_chan), .sample_value(s_val),
    .alarm_cond(acond), .clamp_hi(32'h00001000),
    .program_value(32'h00000abc), .dac_load(dac_ld), .dac_value(dac_val),
    .alarm_flag(), .cal_led(), .module_led(), .sample_stall());
  aio_ctrl_end i_aio_ctrl_end_out (.clk(clk), .nrst(nrst), .link(link2),
    .user_int_fmt(u_int), .user_time_stamp(u_tst), .user_latch_en(u_latch),
    .user_clamp_en(u_clamp), .user_inhibit(u_inh), .user_unlatch(u_unl),
    .user_cal(u_cal), .user_cal_all(u_all), .user_cal_chan(u_chan),
    .user_cal_offset(u_off), .system_time(stime), .consume_ready(cready),
    .rx_valid(), .rx_data(), .connected());
  aio_link_checker i_aio_link_checker (.clk(clk), .nrst(nrst),
    .prod_valid(link.prod_valid), .prod_ready(link.prod_ready),
    .prod_data(link.prod_data), .cfg_int_fmt(link.cfg_int_fmt),
    .cfg_time_stamp(link.cfg_time_stamp), .cfg_latch_en(link.cfg_latch_en),
    .inhibit(link.inhibit), .chassis_system_time(link.chassis_system_time));
  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task stop_test;
    $display("mismatches %0d, checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  task check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task step(input int c);
    repeat (c) @(negedge clk);
  endtask : step
  task push(input logic [1:0] ch, input logic [31:0] v);
    s_valid = 1'b1;
    s_chan = ch;
    s_val = v;
    @(negedge clk);
    s_valid = 1'b0;
  endtask : push
  // Advances first, so one pulse is never taken twice
  task recv(output logic [aio_pkg::WORD_W-1:0] r);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (rx_valid !== 1'b1 && i < 40);
    check(rx_valid, 1'b1);
    r = rx_data;
  endtask : recv
  task none_seen(output int got);
    got = 0;
    repeat (12) begin
      @(negedge clk);
      if (rx_valid === 1'b1) got++;
    end
  endtask : none_seen
  task send(input logic [1:0] ch, input logic [31:0] v, input logic [31:0] e);
    push(ch, v);
    recv(w);
    check(w[112:81], e);
    check(w[1:0], ch);
  endtask : send
  task cal(input logic all, input logic [1:0] ch, input logic [15:0] off);
    u_all = all;
    u_chan = ch;
    u_off = off;
    u_cal = 1'b1;
    step(4);
    check(cal_led, 1'b1);
    u_cal = 1'b0;
    step(4);
    check(cal_led, 1'b0);
  endtask : cal
  // -------------------------------------------------------------
  // Sequence
  // -------------------------------------------------------------
  initial begin
    {s_valid, acond, u_int, u_tst, u_latch, u_clamp, u_unl, u_cal} = '0;
    {u_all, s_chan, u_chan, s_val, u_off, stime} = '0;
    u_inh = 1'b1;
    cready = 1'b1;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    step(1);
    check(link.inhibit, 1'b1);
    check(link.cfg_int_fmt, aio_pkg::FMT_FLOAT);
    u_inh = 1'b0;
    step(3);
    check(connected, 1'b1);
    check(module_led, 1'b1);
    send(2'h1, 32'h3fc00000, 32'h3fc00000);
    check(w[65:2], 64'h0);
    check(dac_ld, 1'b0);
    check(dac_val, 32'h3fc00000);
    // Consumer stalls; one push every 8 cycles, one stamp tick each
    cready = 1'b0;
    n = 0;
    while (sample_stall !== 1'b1 && n < 8) begin
      push(2'h3, 32'h100 + n);
      step(7);
      n++;
    end
    check(n, aio_pkg::FIFO_DEPTH);
    push(2'h3, 32'h0000dead);
    cready = 1'b1;
    for (int k = 0; k < 4; k++) begin
      recv(w);
      check(w[112:81], 32'h100 + k);
      if (k > 0) check(15'(w[80:66] - prev), 15'h0001);
      prev = w[80:66];
    end
    none_seen(n);
    check(n, 0);
    u_tst = 1'b1;
    stime = 64'h0123456789abcdef;
    // Long enough for the echo assertion to see settled time
    step(10);
    send(2'h2, 32'h3f800000, 32'h3f800000);
    check(w[65:2], stime);
    u_tst = 1'b0;
    u_int = 1'b1;
    u_clamp = 1'b1;
    step(10);
    cal(1'b0, 2'h2, 16'h0020);
    send(2'h2, 32'h0000fff0, 32'h00000010);
    send(2'h1, 32'h00007000, 32'h00007000);
    cal(1'b1, 2'h0, 16'hfffe);
    send(2'h1, 32'h00000001, 32'hffffffff);
    send(2'h3, 32'h00008000, 32'hffff8000);
    u_int = 1'b0;
    step(3);
    send(2'h0, 32'h40400000, 32'h00001000);
    u_clamp = 1'b0;
    acond = 1'b1;
    step(2);
    check(alarm_flag, 1'b1);
    acond = 1'b0;
    step(2);
    check(alarm_flag, 1'b0);
    u_latch = 1'b1;
    step(3);
    acond = 1'b1;
    step(2);
    acond = 1'b0;
    step(3);
    check(alarm_flag, 1'b1);
    acond = 1'b1;
    u_unl = 1'b1;
    step(3);
    check(alarm_flag, 1'b1);
    acond = 1'b0;
    step(3);
    check(alarm_flag, 1'b0);
    u_unl = 1'b0;
    u_inh = 1'b1;
    step(3);
    check(connected, 1'b0);
    check(module_led, 1'b0);
    check(dac_ld, 1'b1);
    check(dac_val, 32'h00000abc);
    push(2'h0, 32'h00000055);
    none_seen(n);
    check(n, 0);
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    $display("ERROR %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : test_analog_io_timestamp_exchange
`default_nettype wire
